// [logic/iod_pkg.sv]
// Constants shared by the diagnostic and process-data register bank
package iod_pkg;

	// ----------------------------------------------------------------
	// Register numbers
	// ----------------------------------------------------------------
	localparam logic [15:0] IOD_ADDR_STATUS    = 16'h1f3c;
	localparam logic [15:0] IOD_ADDR_DIAG_FLG  = 16'h1f3d;
	localparam logic [15:0] IOD_ADDR_DIAG_LOC  = 16'h1f3e;
	localparam logic [15:0] IOD_ADDR_IN_IMAGE  = 16'h1f40;
	localparam logic [15:0] IOD_ADDR_OUT_IMAGE = 16'h2328;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int IOD_BIT_OUT_SHORT   = 0;
	localparam int IOD_BIT_SNS_UNDER   = 2;
	localparam int IOD_BIT_SNS_SURGE   = 3;
	localparam int IOD_BIT_SNS_SHORT   = 4;
	localparam int IOD_BIT_ACT_UNDER   = 6;
	localparam int IOD_BIT_ACT_SURGE   = 7;
	localparam int IOD_BIT_ACT_SHORT   = 8;
	localparam int IOD_BIT_OVERTEMP    = 10;
	localparam int IOD_BIT_GEN_ERROR   = 0;
	localparam int IOD_NUM_CHAN        = 8;
	localparam int IOD_NUM_FAULT_PINS  = 9;

	// ----------------------------------------------------------------
	// Codes and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] IOD_LOC_NONE     = 16'h0000;
	localparam logic [15:0] IOD_LOC_GROUP_LO = 16'h0001;
	localparam logic [15:0] IOD_LOC_GROUP_HI = 16'h0002;
	localparam logic [7:0]  IOD_EXC_NONE     = 8'h00;
	localparam logic [7:0]  IOD_EXC_ADDRESS  = 8'h02;
	localparam logic [7:0]  IOD_HIGH_BYTE    = 8'h00;
	localparam logic [7:0]  IOD_OUT_RESET    = 8'h00;
	localparam logic [15:0] IOD_WORD_ZERO    = 16'h0000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned IOD_CLK_HZ       = 10_000_000;
	localparam int unsigned IOD_CONNECT_MS   = 350;
	localparam int unsigned IOD_CYCLIC_MS    = 500;
	localparam int unsigned IOD_CONNECT_CYC  = IOD_CONNECT_MS * (IOD_CLK_HZ / 1000);
	localparam int unsigned IOD_CYCLIC_CYC   = IOD_CYCLIC_MS * (IOD_CLK_HZ / 1000);
	localparam int          IOD_TIMER_W      = 23;

	// ----------------------------------------------------------------
	// Transaction states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		IOD_ST_IDLE,
		IOD_ST_RESP,
		IOD_ST_TX_HI,
		IOD_ST_TX_LO
	} iod_state_e;

endpackage : iod_pkg

// [logic/iod_regs.sv]
// Diagnostic and process-data register bank of an 8-in/8-out I/O device
//
// Overview of operation
// - Output short or overload sets diag bit 0; group given in location word.
// - Sensor supply faults: undervoltage bit 2, surge bit 3, short bit 4.
// - Actuator supply faults: undervoltage bit 6, surge bit 7, short bit 8.
// - Device overtemperature sets diag bit 10.
// - Location word: 0 none, 1 outputs 1-4, 2 outputs 5-8.
// - Input n appears in bit n-1 of the input word low byte.
// - Bit n-1 of the output word low byte drives output n.
// - Connection requests accepted within 350 ms after power-up.
// - Cyclic process-data connection possible within 500 ms after power-up.
// - Sixteen-bit words map one-to-one and travel high byte first.
// - Single-byte process data sits in the register low byte.
// - High byte of byte-wide data reads zero; writes to it are dropped.
// - Writes to read-only registers change nothing and answer exception 02.
// - Status bit 0 is set while any diag bit is set.
`timescale 1ns/1ps
module iod_regs
	import iod_pkg::*;
#(
	parameter int unsigned CONNECT_CYC = IOD_CONNECT_CYC,
	parameter int unsigned CYCLIC_CYC  = IOD_CYCLIC_CYC
) (
	// Clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	// Register requests
	input  wire logic        req_valid_in,
	input  wire logic        req_write_in,
	input  wire logic [15:0] req_addr_in,
	input  wire logic [15:0] req_wdata_in,
	output logic             req_ready_out,
	// Register answers
	output logic             resp_valid_out,
	output logic [15:0]      resp_data_out,
	output logic [7:0]       resp_exc_out,
	output logic             tx_byte_valid_out,
	output logic [7:0]       tx_byte_out,
	// Fault sensing pins
	input  wire logic        out_short_lo_in,
	input  wire logic        out_short_hi_in,
	input  wire logic        sns_under_in,
	input  wire logic        sns_surge_in,
	input  wire logic        sns_short_in,
	input  wire logic        act_under_in,
	input  wire logic        act_surge_in,
	input  wire logic        act_short_in,
	input  wire logic        overtemp_in,
	// Digital channels
	input  wire logic [7:0]  digital_input_channel_in,
	output logic [7:0]       digital_output_channel_out,
	// Readiness
	output logic             connect_ready_out,
	output logic             cyclic_ready_out
);

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	// Place of each fault pin inside the synchronised bundle
	localparam int PIN_OUT_LO    = 0;
	localparam int PIN_OUT_HI    = 1;
	localparam int PIN_SNS_UNDER = 2;
	localparam int PIN_SNS_SURGE = 3;
	localparam int PIN_SNS_SHORT = 4;
	localparam int PIN_ACT_UNDER = 5;
	localparam int PIN_ACT_SURGE = 6;
	localparam int PIN_ACT_SHORT = 7;
	localparam int PIN_OVERTEMP  = 8;

	logic [IOD_NUM_FAULT_PINS-1:0] fault_pins;
	logic [IOD_NUM_FAULT_PINS-1:0] fault_sync;
	logic [IOD_NUM_CHAN-1:0]       din_sync;

	// Levels only; a fault pulse shorter than a clock may be missed
	assign fault_pins = {
		overtemp_in,
		act_short_in,
		act_surge_in,
		act_under_in,
		sns_short_in,
		sns_surge_in,
		sns_under_in,
		out_short_hi_in,
		out_short_lo_in
	};

	iod_sync #(
		.WIDTH (IOD_NUM_FAULT_PINS)
	) u_fault_sync (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.pin_in     (fault_pins),
		.level_out  (fault_sync)
	);

	iod_sync #(
		.WIDTH (IOD_NUM_CHAN)
	) u_din_sync (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.pin_in     (digital_input_channel_in),
		.level_out  (din_sync)
	);

	// ----------------------------------------------------------------
	// Start-up readiness
	// ----------------------------------------------------------------
	logic connect_ready;
	logic cyclic_ready;

	iod_startup #(
		.CONNECT_CYC (CONNECT_CYC),
		.CYCLIC_CYC  (CYCLIC_CYC)
	) u_startup (
		.ref_clk_in        (ref_clk_in),
		.rst_in            (rst_in),
		.connect_ready_out (connect_ready),
		.cyclic_ready_out  (cyclic_ready)
	);

	assign connect_ready_out = connect_ready;
	assign cyclic_ready_out  = cyclic_ready;

	// ----------------------------------------------------------------
	// Live diagnostic words
	// ----------------------------------------------------------------
	logic [15:0] diag_fault_flags;
	logic [15:0] diag_fault_location;
	logic [15:0] status_word;
	logic [15:0] input_image_word;

	always_comb begin
		diag_fault_flags = IOD_WORD_ZERO;
		diag_fault_flags[IOD_BIT_OUT_SHORT] = fault_sync[PIN_OUT_LO] | fault_sync[PIN_OUT_HI];
		diag_fault_flags[IOD_BIT_SNS_UNDER] = fault_sync[PIN_SNS_UNDER];
		diag_fault_flags[IOD_BIT_SNS_SURGE] = fault_sync[PIN_SNS_SURGE];
		diag_fault_flags[IOD_BIT_SNS_SHORT] = fault_sync[PIN_SNS_SHORT];
		diag_fault_flags[IOD_BIT_ACT_UNDER] = fault_sync[PIN_ACT_UNDER];
		diag_fault_flags[IOD_BIT_ACT_SURGE] = fault_sync[PIN_ACT_SURGE];
		diag_fault_flags[IOD_BIT_ACT_SHORT] = fault_sync[PIN_ACT_SHORT];
		diag_fault_flags[IOD_BIT_OVERTEMP]  = fault_sync[PIN_OVERTEMP];
	end

	// ----------------------------------------------------------------
	// Fault location
	// ----------------------------------------------------------------

	// One code only; lower group wins when both groups are shorted
	always_comb begin
		if (fault_sync[PIN_OUT_LO]) begin
			diag_fault_location = IOD_LOC_GROUP_LO;
		end else if (fault_sync[PIN_OUT_HI]) begin
			diag_fault_location = IOD_LOC_GROUP_HI;
		end else begin
			diag_fault_location = IOD_LOC_NONE;
		end
	end

	// Only the general error bit; the net-fail bit is not built here
	always_comb begin
		status_word = IOD_WORD_ZERO;
		status_word[IOD_BIT_GEN_ERROR] = |diag_fault_flags;
	end

	assign input_image_word = {IOD_HIGH_BYTE, din_sync};

	// ----------------------------------------------------------------
	// Output image register
	// ----------------------------------------------------------------
	logic [7:0] out_image_q;
	logic [7:0] out_image_d;
	logic       take;

	assign take = req_valid_in & req_ready_out;

	always_comb begin
		out_image_d = out_image_q;
		if (take && req_write_in && req_addr_in == IOD_ADDR_OUT_IMAGE) begin
			out_image_d = req_wdata_in[7:0];
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			out_image_q <= IOD_OUT_RESET;
		end else begin
			out_image_q <= out_image_d;
		end
	end

	// Outputs stay off from reset until the client writes them
	assign digital_output_channel_out = out_image_q;

	// ----------------------------------------------------------------
	// Request decode and answer sequencing
	// ----------------------------------------------------------------
	iod_state_e  state_q;
	iod_state_e  state_d;
	logic [15:0] data_q;
	logic [15:0] data_d;
	logic [7:0]  exc_q;
	logic [7:0]  exc_d;
	logic [7:0]  tx_q;
	logic [7:0]  tx_d;
	logic [15:0] read_word;
	logic        addr_hit;
	logic        wr_image;
	logic        refuse;
	logic [15:0] answer_word;
	logic [7:0]  answer_exc;

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------

	always_comb begin
		addr_hit  = 1'b1;
		read_word = IOD_WORD_ZERO;
		case (req_addr_in)
			IOD_ADDR_STATUS:    read_word = status_word;
			IOD_ADDR_DIAG_FLG:  read_word = diag_fault_flags;
			IOD_ADDR_DIAG_LOC:  read_word = diag_fault_location;
			IOD_ADDR_IN_IMAGE:  read_word = input_image_word;
			IOD_ADDR_OUT_IMAGE: read_word = {IOD_HIGH_BYTE, out_image_q};
			default:            addr_hit  = 1'b0;
		endcase
	end

	// Refused requests answer zero data and touch no register
	always_comb begin
		wr_image    = req_write_in && (req_addr_in == IOD_ADDR_OUT_IMAGE);
		refuse      = !addr_hit || (req_write_in && !wr_image);
		answer_word = read_word;
		answer_exc  = IOD_EXC_NONE;
		if (refuse) begin
			answer_word = IOD_WORD_ZERO;
			answer_exc  = IOD_EXC_ADDRESS;
		end else if (wr_image) begin
			answer_word = {IOD_HIGH_BYTE, req_wdata_in[7:0]};
		end
	end

	// ----------------------------------------------------------------
	// Answer sequencing
	// ----------------------------------------------------------------
	// Busy for the whole answer so a second request never overlaps the bytes
	assign req_ready_out = connect_ready && (state_q == IOD_ST_IDLE);

	always_comb begin
		state_d = state_q;
		data_d  = data_q;
		exc_d   = exc_q;
		tx_d    = tx_q;
		case (state_q)
			IOD_ST_IDLE: begin
				if (take) begin
					state_d = IOD_ST_RESP;
					data_d  = answer_word;
					exc_d   = answer_exc;
				end
			end
			IOD_ST_RESP: begin
				state_d = IOD_ST_TX_HI;
				tx_d    = data_q[15:8];
			end
			IOD_ST_TX_HI: begin
				state_d = IOD_ST_TX_LO;
				tx_d    = data_q[7:0];
			end
			IOD_ST_TX_LO: begin
				state_d = IOD_ST_IDLE;
			end
			default: begin
				state_d = IOD_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state_q <= IOD_ST_IDLE;
			data_q  <= IOD_WORD_ZERO;
			exc_q   <= IOD_EXC_NONE;
			tx_q    <= IOD_HIGH_BYTE;
		end else begin
			state_q <= state_d;
			data_q  <= data_d;
			exc_q   <= exc_d;
			tx_q    <= tx_d;
		end
	end

	// ----------------------------------------------------------------
	// Answer outputs
	// ----------------------------------------------------------------

	assign resp_valid_out    = (state_q == IOD_ST_RESP);
	assign resp_data_out     = data_q;
	assign resp_exc_out      = exc_q;
	assign tx_byte_valid_out = (state_q == IOD_ST_TX_HI) || (state_q == IOD_ST_TX_LO);
	assign tx_byte_out       = tx_q;

endmodule : iod_regs

// [logic/iod_startup.sv]
// Start-up timer that raises the connection and cyclic readiness levels
`timescale 1ns/1ps
module iod_startup
	import iod_pkg::*;
#(
	parameter int unsigned CONNECT_CYC = IOD_CONNECT_CYC,
	parameter int unsigned CYCLIC_CYC  = IOD_CYCLIC_CYC
) (
	// Clock and reset
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	// Readiness
	output logic      connect_ready_out,
	output logic      cyclic_ready_out
);

	localparam logic [IOD_TIMER_W-1:0] CONNECT_LIM = IOD_TIMER_W'(CONNECT_CYC);
	localparam logic [IOD_TIMER_W-1:0] CYCLIC_LIM  = IOD_TIMER_W'(CYCLIC_CYC);

	logic [IOD_TIMER_W-1:0] count_q;
	logic [IOD_TIMER_W-1:0] count_d;
	logic                   connect_q;
	logic                   connect_d;
	logic                   cyclic_q;
	logic                   cyclic_d;

	// ----------------------------------------------------------------
	// Counter saturates once both levels are up
	// ----------------------------------------------------------------
	always_comb begin
		count_d   = count_q;
		connect_d = connect_q;
		cyclic_d  = cyclic_q;
		if (!cyclic_q) begin
			count_d = count_q + IOD_TIMER_W'(1);
		end
		if (count_q >= CONNECT_LIM - IOD_TIMER_W'(1)) begin
			connect_d = 1'b1;
		end
		if (count_q >= CYCLIC_LIM - IOD_TIMER_W'(1)) begin
			cyclic_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			count_q   <= '0;
			connect_q <= 1'b0;
			cyclic_q  <= 1'b0;
		end else begin
			count_q   <= count_d;
			connect_q <= connect_d;
			cyclic_q  <= cyclic_d;
		end
	end

	assign connect_ready_out = connect_q;
	assign cyclic_ready_out  = cyclic_q;

endmodule : iod_startup

// [logic/iod_sync.sv]
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module iod_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             rst_in,
	// Pins and synchronised levels
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// ----------------------------------------------------------------
	// Per-bit stages
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			always_comb begin
				meta_d[gi] = pin_in[gi];
				sync_d[gi] = meta_q[gi];
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign level_out = sync_q;

endmodule : iod_sync

// [tb/iod_client.sv]
// Client model that rebuilds answer words from the byte stream
`timescale 1ns/1ps
module iod_client (
	// Clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	// Bytes from the block
	input  wire logic       tx_byte_valid_in,
	input  wire logic [7:0] tx_byte_in,
	// Rebuilt word
	output logic            word_valid_out,
	output logic [15:0]     word_out
);
	logic [7:0]  hi_q, hi_d;
	logic        half_q, half_d, wv_d;
	logic [15:0] w_d;
	// First byte is the high one
	always_comb begin
		half_d = half_q;
		hi_d   = hi_q;
		wv_d   = 1'b0;
		w_d    = word_out;
		if (tx_byte_valid_in) begin
			half_d = !half_q;
			if (half_q) begin
				wv_d = 1'b1;
				w_d  = {hi_q, tx_byte_in};
			end else begin
				hi_d = tx_byte_in;
			end
		end
	end
	always_ff @(posedge ref_clk_in) begin
		half_q         <= rst_in ? 1'b0 : half_d;
		hi_q           <= hi_d;
		word_valid_out <= rst_in ? 1'b0 : wv_d;
		word_out       <= w_d;
	end
endmodule : iod_client

// [tb/iod_regs_sva.sv]
// Port assertions for the register bank
`timescale 1ns/1ps
module iod_regs_sva
	import iod_pkg::*;
#(
	parameter int unsigned CONNECT_CYC = 20,
	parameter int unsigned CYCLIC_CYC  = 30
) (
	input wire logic        ref_clk_in,
	input wire logic        rst_in,
	input wire logic        req_valid_in,
	input wire logic        req_write_in,
	input wire logic [15:0] req_addr_in,
	input wire logic [15:0] req_wdata_in,
	input wire logic        req_ready_out,
	input wire logic        resp_valid_out,
	input wire logic [15:0] resp_data_out,
	input wire logic [7:0]  resp_exc_out,
	input wire logic        tx_byte_valid_out,
	input wire logic [7:0]  tx_byte_out,
	input wire logic [7:0]  digital_output_channel_out,
	input wire logic        connect_ready_out,
	input wire logic        cyclic_ready_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	wire logic   take = req_valid_in && req_ready_out;
	logic [31:0] up_q;
	// Edges since release; margin of two either side of the timer
	always_ff @(posedge ref_clk_in) begin
		up_q <= rst_in ? 32'h0 : up_q + 32'h1;
	end
	property p_early; up_q + 32'h2 <= CONNECT_CYC |-> !connect_ready_out && !req_ready_out;
	endproperty
	a_early: assert property (p_early) else $error("ready too early");
	property p_late; up_q >= CYCLIC_CYC + 2 |-> cyclic_ready_out && connect_ready_out; endproperty
	a_late: assert property (p_late) else $error("ready too late");
	property p_resp; take |=> resp_valid_out ##1 !resp_valid_out && !req_ready_out; endproperty
	a_resp: assert property (p_resp) else $error("answer pulse wrong");
	property p_tx; resp_valid_out |=> tx_byte_valid_out && tx_byte_out == resp_data_out[15:8]
		##1 tx_byte_valid_out && tx_byte_out == resp_data_out[7:0] ##1 !tx_byte_valid_out;
	endproperty
	a_tx: assert property (p_tx) else $error("byte order wrong");
	property p_ro; take && req_write_in && req_addr_in != IOD_ADDR_OUT_IMAGE |=>
		resp_exc_out == IOD_EXC_ADDRESS && resp_data_out == IOD_WORD_ZERO
		&& $stable(digital_output_channel_out);
	endproperty
	a_ro: assert property (p_ro) else $error("read-only write not refused");
	property p_wr; take && req_write_in && req_addr_in == IOD_ADDR_OUT_IMAGE |=>
		{8'h00, digital_output_channel_out} == ($past(req_wdata_in) & 16'h00ff)
		&& resp_data_out == ($past(req_wdata_in) & 16'h00ff);
	endproperty
	a_wr: assert property (p_wr) else $error("output write wrong");
	property p_rsv; take && !req_write_in && req_addr_in == IOD_ADDR_DIAG_FLG |=>
		(resp_data_out & 16'hfa22) == 16'h0000;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved diag bit set");
	property p_img; take && !req_write_in && req_addr_in == IOD_ADDR_IN_IMAGE |=>
		resp_data_out[15:8] == IOD_HIGH_BYTE && resp_exc_out == IOD_EXC_NONE;
	endproperty
	a_img: assert property (p_img) else $error("input high byte set");
endmodule : iod_regs_sva
bind iod_regs iod_regs_sva #(.CONNECT_CYC(CONNECT_CYC), .CYCLIC_CYC(CYCLIC_CYC))
	iod_regs_sva_i (.*);

// [tb/test_iod_regs.sv]
// Self-checking bench for the register bank
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_iod_regs
	import iod_pkg::*;
;
	logic        ref_clk_in = 1'b0, rst_in = 1'b1, req_valid_in = 1'b0, req_write_in = 1'b0;
	logic [15:0] req_addr_in = 16'h0, req_wdata_in = 16'h0;
	logic [8:0]  fault = 9'h0;
	logic [7:0]  din = 8'h0;
	logic        req_ready_out, resp_valid_out, tx_byte_valid_out, word_valid_out;
	logic        connect_ready_out, cyclic_ready_out;
	logic [15:0] resp_data_out, word_out, last_q;
	logic [7:0]  resp_exc_out, tx_byte_out, digital_output_channel_out;
	logic [23:0] exp_q[$];
	int          miscompares = 0, check_count = 0, n, words = 0, answers = 0;
	localparam logic [15:0] RO[5] = '{IOD_ADDR_STATUS, IOD_ADDR_DIAG_FLG, IOD_ADDR_DIAG_LOC,
		IOD_ADDR_IN_IMAGE, 16'h1f3f};
	always #50 ref_clk_in = ~ref_clk_in;
	// Short timer counts keep the start-up wait brief
	localparam int unsigned CONN_CYC = 20;
	localparam int unsigned CYCL_CYC = 30;
	iod_regs #(.CONNECT_CYC(CONN_CYC), .CYCLIC_CYC(CYCL_CYC)) iod_regs_i (.ref_clk_in, .rst_in,
		.req_valid_in, .req_write_in, .req_addr_in, .req_wdata_in, .req_ready_out,
		.resp_valid_out, .resp_data_out, .resp_exc_out, .tx_byte_valid_out, .tx_byte_out,
		.out_short_lo_in(fault[0]), .out_short_hi_in(fault[1]), .sns_under_in(fault[2]),
		.sns_surge_in(fault[3]), .sns_short_in(fault[4]), .act_under_in(fault[5]),
		.act_surge_in(fault[6]), .act_short_in(fault[7]), .overtemp_in(fault[8]),
		.digital_input_channel_in(din), .digital_output_channel_out, .connect_ready_out,
		.cyclic_ready_out);
	iod_client iod_client_i (.ref_clk_in, .rst_in, .tx_byte_valid_in(tx_byte_valid_out),
		.tx_byte_in(tx_byte_out), .word_valid_out, .word_out);
	task automatic wrap_up;
		$display("checks=%0d mismatches=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up
	task automatic xfer(input logic wr, input logic [15:0] a, wd, input logic [23:0] e);
		int k;
		@(posedge ref_clk_in);
		req_valid_in <= 1'b1;
		req_write_in <= wr;
		req_addr_in  <= a;
		req_wdata_in <= wd;
		for (k = 0; k < 50; k++) begin
			@(posedge ref_clk_in);
			if (req_ready_out === 1'b1) break;
		end
		if (k == 50) begin
			miscompares++;
			wrap_up();
		end
		exp_q.push_back(e);
		req_valid_in <= 1'b0;
	endtask : xfer
	function automatic logic [15:0] diag(input logic [8:0] f);
		diag = 16'h0000;
		diag[0] = f[0] | f[1];
		diag[4:2] = f[4:2];
		diag[8:6] = f[7:5];
		diag[10] = f[8];
	endfunction : diag
	always @(posedge ref_clk_in) begin : mon
		logic [23:0] e;
		if (resp_valid_out === 1'b1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 24'hxxxxxx;
			`CHK({resp_data_out, resp_exc_out}, e)
			last_q <= resp_data_out;
			answers++;
		end
		if (word_valid_out === 1'b1) begin
			`CHK(word_out, last_q)
			words++;
		end
	end
	initial begin
		int k;
		logic [15:0] dg, wv, l;
		void'($urandom(32'hd101));
		repeat (6) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		n = 0;
		while (connect_ready_out !== 1'b1 && n < 100) begin
			@(posedge ref_clk_in);
			n++;
		end
		`CHK(n >= CONN_CYC - 1 && n <= CONN_CYC + 2, 1'b1)
		while (cyclic_ready_out !== 1'b1 && n < 100) begin
			@(posedge ref_clk_in);
			n++;
		end
		`CHK(n >= CYCL_CYC - 1 && n <= CYCL_CYC + 2, 1'b1)
		if (n >= 100) wrap_up();
		for (k = 0; k < 24; k++) begin
			@(posedge ref_clk_in);
			fault <= (k < 9) ? 9'h1 << k : (k == 9) ? 9'h0 : 9'($urandom);
			din   <= 8'($urandom);
			wv = 16'($urandom);
			repeat (4) @(posedge ref_clk_in);
			dg = diag(fault);
			l = fault[0] ? IOD_LOC_GROUP_LO : fault[1] ? IOD_LOC_GROUP_HI : IOD_LOC_NONE;
			xfer(1'b0, IOD_ADDR_DIAG_FLG, 16'h0, {dg, IOD_EXC_NONE});
			xfer(1'b0, IOD_ADDR_DIAG_LOC, 16'h0, {l, IOD_EXC_NONE});
			xfer(1'b0, IOD_ADDR_STATUS, 16'h0, {15'h0, |dg, IOD_EXC_NONE});
			xfer(1'b0, IOD_ADDR_IN_IMAGE, 16'h0, {8'h00, din, IOD_EXC_NONE});
			xfer(1'b1, IOD_ADDR_OUT_IMAGE, wv, {8'h00, wv[7:0], IOD_EXC_NONE});
			xfer(1'b1, RO[k % 5], ~wv, {16'h0, IOD_EXC_ADDRESS});
			xfer(1'b0, IOD_ADDR_OUT_IMAGE, 16'h0, {8'h00, wv[7:0], IOD_EXC_NONE});
			xfer(1'b0, 16'h0000, 16'h0, {16'h0, IOD_EXC_ADDRESS});
			@(posedge ref_clk_in);
			`CHK(digital_output_channel_out, wv[7:0])
		end
		repeat (6) @(posedge ref_clk_in);
		`CHK(exp_q.size(), 0)
		`CHK(words, answers)
		wrap_up();
	end
endmodule : test_iod_regs
